//--- rtl/sgc_pkg.sv
// package: register map, fields, reset values, states and timing
package sgc_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADR_PSMODE  = 8'h00; // power_save_mode_select
  localparam logic [7:0] ADR_SETTLE  = 8'h04; // stabilization_time_select
  localparam logic [7:0] ADR_PSCTL   = 8'h08; // power_save_control
  localparam logic [7:0] ADR_PROCCLK = 8'h0C; // processor_clock_control
  localparam logic [7:0] ADR_STATUS  = 8'h10; // read-only state view
  localparam logic [7:0] ADR_PLLCFG  = 8'h14; // multiplier select

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PSMODE  = 8'h00;
  localparam logic [7:0] RST_SETTLE  = 8'h01;
  localparam logic [7:0] RST_PSCTL   = 8'h00;
  localparam logic [7:0] RST_PROCCLK = 8'h00;
  localparam logic [7:0] RST_PLLCFG  = 8'h00;

  // ==========================================================
  // field positions
  localparam int STOP_SEL_BIT   = 0; // 0 idle, 1 software stop
  localparam int SETTLE_SEL_BIT = 0; // 0 short wait, 1 long wait
  localparam int STBY_REQ_BIT   = 1; // standby_request
  localparam int INT_DIS_BIT    = 4; // maskable release disable
  localparam int NMI_DIS_BIT    = 5; // nmi release disable
  localparam int FB_DIS_BIT     = 5; // feedback_resistor_disable
  localparam int BIT_VAL_POS    = 3; // value bit in a 1-bit write

  // ==========================================================
  // timing: wait in oscillator periods, oscillator periods per counter tick
  localparam int SHORT_OSC_PER  = 2 ** 14;
  localparam int LONG_OSC_PER   = 2 ** 16;
  localparam int PER_PER_CYCLE  = 1;
  localparam int SHORT_CYC      =
    (SHORT_OSC_PER + PER_PER_CYCLE - 1) / PER_PER_CYCLE;
  localparam int LONG_CYC       =
    (LONG_OSC_PER + PER_PER_CYCLE - 1) / PER_PER_CYCLE;
  localparam int CNT_W          = 17;

  // ==========================================================
  // operating modes, one-hot
  typedef enum logic [5:0] {
    ST_NORMAL   = 6'h01,
    ST_HALT     = 6'h02,
    ST_IDLE     = 6'h04,
    ST_STOP     = 6'h08,
    ST_WAIT_OSC = 6'h10,
    ST_SETTLE   = 6'h20
  } sgc_state_t;

endpackage

//--- rtl/sgc_settle_cnt.sv
// module: oscillation stabilisation down-counter
`timescale 1ns/1ps
module sgc_settle_cnt #(
  parameter int CNT_W     = 17,
  parameter int SHORT_CYC = 16384,
  parameter int LONG_CYC  = 65536
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic load,
  input  wire logic long_sel,
  output logic      done
);

  // ==========================================================
  // counter
  logic [CNT_W-1:0] cnt_r; // remaining cycles minus one
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] len_m1; // selected length minus one

  // select wait length
  assign len_m1  = long_sel ? CNT_W'(LONG_CYC - 1)
                            : CNT_W'(SHORT_CYC - 1);
  // load wins, else count down to zero and rest there
  assign cnt_nxt = load ? len_m1
                 : (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  // zero means wait over; only looked at while settling
  assign done    = (cnt_r == '0);

  // count register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

//--- rtl/sgc_gate_map.sv
// module: clock enables for each operating mode
`timescale 1ns/1ps
module sgc_gate_map (
  input  wire sgc_pkg::sgc_state_t state,
  input  wire logic                clk_through,
  input  wire logic                fb_dis,
  output logic                     osc_en,
  output logic                     pll_en,
  output logic                     sys_en,
  output logic                     per_en,
  output logic                     cpu_en,
  output logic                     wdt_en
);
  import sgc_pkg::*;

  // ==========================================================
  // decode
  logic amp_on; // oscillator amplifier only for a resonator
  logic pll_on; // pll only outside clock-through mode

  assign amp_on = ~fb_dis;
  assign pll_on = ~clk_through;

  // one row per mode
  always_comb begin
    {osc_en, pll_en, sys_en, per_en, cpu_en, wdt_en} = 6'h00;
    case (state)
      ST_NORMAL: begin
        {osc_en, pll_en} = {amp_on, pll_on};
        {sys_en, per_en, cpu_en, wdt_en} = 4'hF;
      end
      ST_HALT: begin // cpu clock only stops
        {osc_en, pll_en} = {amp_on, pll_on};
        {sys_en, per_en, wdt_en} = 3'h7;
      end
      ST_IDLE: begin // source clocks only
        {osc_en, pll_en} = {amp_on, pll_on};
      end
      ST_WAIT_OSC, ST_SETTLE: begin // watchdog runs while settling
        {osc_en, pll_en} = {amp_on, pll_on};
        wdt_en = 1'b1;
      end
      default: begin // stop: everything off
        osc_en = 1'b0;
      end
    endcase
  end

endmodule

//--- rtl/sgc_ctrl.sv
// module: standby mode sequencing and clock gating control
//
// Summary of operation
// - stop_select 0 idle, 1 software stop
// - stop_select only acts with standby_request set
// - mode register resets zero; upper bits stay zero
// - mode register takes byte and bit accesses
// - settle select register resets to 0x01
// - settle select register is byte access only
// - settle select 0 short, 1 long wait
// - wait follows interrupt release from stop
// - counting starts once oscillation is running
// - reset ends stop without any wait count
// - halt, idle and stop gate their clocks
// - settling runs watchdog and sources only
// - reset gates clocks by pll or through
// - wait also applies with external clock
// - multiplier or clock-through drives operating clock
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module sgc_ctrl #(
  parameter int SHORT_CYC = sgc_pkg::SHORT_CYC,
  parameter int LONG_CYC  = sgc_pkg::LONG_CYC
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       reg_bit,
  output logic      [7:0] reg_rdata,
  input  wire logic       halt_req,
  input  wire logic       int_req,
  input  wire logic       nmi_req,
  input  wire logic       osc_stable_pin,
  input  wire logic       clock_through_pin,
  output logic            osc_en,
  output logic            pll_en,
  output logic            sysclk_en,
  output logic            periph_en,
  output logic            cpu_en,
  output logic            wdt_en,
  output logic            core_hold,
  output logic      [1:0] pll_mult,
  output logic      [1:0] cpu_div,
  output logic            clock_through,
  output logic            feedback_resistor_disable
);
  import sgc_pkg::*;

  // ==========================================================
  // byte update for 8-bit or 1-bit writes
  // a 1-bit write names the bit in wdata[2:0], value in wdata[3]
  function automatic logic [7:0] bit_merge(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic       bit_mode
  );
    logic [7:0] res;
    res = old;
    if (bit_mode) begin
      res[wdata[2:0]] = wdata[BIT_VAL_POS];
    end else begin
      res = wdata;
    end
    return res;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic ct_s1_r;   // clock-through pin, first stage
  logic ct_s2_r;   // clock-through pin, second stage
  logic os_s1_r;   // oscillation running, first stage
  logic os_s2_r;   // oscillation running, second stage
  logic ct_mode_r; // strap caught while reset is held

  // two flops per pin; not reset, they just follow the pins
  always_ff @(posedge clock) begin
    ct_s1_r <= clock_through_pin;
    ct_s2_r <= ct_s1_r;
    os_s1_r <= osc_stable_pin;
    os_s2_r <= os_s1_r;
  end

  // mode strap: pin must be fixed during reset, so sample then
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ct_mode_r <= ct_s2_r;
    end
  end

  // ==========================================================
  // register state
  logic       stop_sel_r;   // stop_select
  logic       settle_sel_r; // settle_time_select
  logic       stby_req_r;   // standby_request
  logic       int_dis_r;    // maskable release disabled
  logic       nmi_dis_r;    // nmi release disabled
  logic       fb_dis_r;     // feedback_resistor_disable
  logic [1:0] cpu_div_r;    // cpu clock divide select
  logic [1:0] pll_mult_r;   // 1.25 / 2.5 / 5 / 10
  logic [7:0] rdata_r;      // read answer
  sgc_state_t state_r;
  sgc_state_t state_nxt;

  // ==========================================================
  // address decode
  logic       wr_psmode;
  logic       wr_settle;
  logic       wr_psctl;
  logic       wr_procclk;
  logic       wr_pllcfg;
  logic [7:0] psmode_rd;  // reserved bits read zero
  logic [7:0] settle_rd;
  logic [7:0] psctl_rd;
  logic [7:0] procclk_rd;
  logic [7:0] status_rd;
  logic [7:0] pllcfg_rd;
  logic [7:0] psmode_new;
  logic [7:0] psctl_new;
  logic [7:0] procclk_new;
  logic [7:0] rd_mux;

  assign wr_psmode  = reg_wr && (reg_addr == ADR_PSMODE);
  // byte access only: a 1-bit write is dropped
  assign wr_settle  = reg_wr && !reg_bit &&
                      (reg_addr == ADR_SETTLE);
  assign wr_psctl   = reg_wr && (reg_addr == ADR_PSCTL);
  assign wr_procclk = reg_wr && (reg_addr == ADR_PROCCLK);
  assign wr_pllcfg  = reg_wr && !reg_bit && (reg_addr == ADR_PLLCFG);

  // read views
  assign psmode_rd  = {7'h00, stop_sel_r};
  assign settle_rd  = {7'h00, settle_sel_r};
  assign psctl_rd   = {2'h0, nmi_dis_r, int_dis_r, 2'h0,
                       stby_req_r, 1'b0};
  assign procclk_rd = {2'h0, fb_dis_r, 3'h0, cpu_div_r};
  assign status_rd  = {os_s2_r, ct_mode_r, state_r};
  assign pllcfg_rd  = {6'h00, pll_mult_r};

  // new byte for a write, whole byte or single bit
  assign psmode_new  = bit_merge(psmode_rd, reg_wdata,
                                 reg_bit);
  assign psctl_new   = bit_merge(psctl_rd, reg_wdata, reg_bit);
  assign procclk_new = bit_merge(procclk_rd, reg_wdata, reg_bit);

  // read mux; unmapped addresses read zero
  assign rd_mux = (reg_addr == ADR_PSMODE)  ? psmode_rd  :
                  (reg_addr == ADR_SETTLE)  ? settle_rd  :
                  (reg_addr == ADR_PSCTL)   ? psctl_rd   :
                  (reg_addr == ADR_PROCCLK) ? procclk_rd :
                  (reg_addr == ADR_STATUS)  ? status_rd  :
                  (reg_addr == ADR_PLLCFG)  ? pllcfg_rd  : 8'h00;

  // ==========================================================
  // register writes
  // mode register: only bit 0 is stored, so 1..7 stay zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stop_sel_r <= RST_PSMODE[STOP_SEL_BIT];
    end else if (wr_psmode) begin
      stop_sel_r <= psmode_new[STOP_SEL_BIT];
    end
  end

  // settle select: long wait after reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      settle_sel_r <= RST_SETTLE[SETTLE_SEL_BIT];
    end else if (wr_settle) begin
      settle_sel_r <= reg_wdata[SETTLE_SEL_BIT];
    end
  end

  // release event and standby request clear
  logic release_evt; // enabled wake-up source present
  logic stby_clr;    // hardware clears request on wake

  assign release_evt = (int_req && !int_dis_r) ||
                       (nmi_req && !nmi_dis_r);
  assign stby_clr    = ((state_r == ST_IDLE) ||
                        (state_r == ST_STOP)) && release_evt;

  // power save control; a software write beats the wake clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stby_req_r <= RST_PSCTL[STBY_REQ_BIT];
      int_dis_r  <= RST_PSCTL[INT_DIS_BIT];
      nmi_dis_r  <= RST_PSCTL[NMI_DIS_BIT];
    end else if (wr_psctl) begin
      stby_req_r <= psctl_new[STBY_REQ_BIT];
      int_dis_r  <= psctl_new[INT_DIS_BIT];
      nmi_dis_r  <= psctl_new[NMI_DIS_BIT];
    end else if (stby_clr) begin
      stby_req_r <= 1'b0;
    end
  end

  // processor clock control and multiplier select
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fb_dis_r   <= RST_PROCCLK[FB_DIS_BIT];
      cpu_div_r  <= RST_PROCCLK[1:0];
      pll_mult_r <= RST_PLLCFG[1:0];
    end else begin
      if (wr_procclk) begin
        fb_dis_r  <= procclk_new[FB_DIS_BIT];
        cpu_div_r <= procclk_new[1:0];
      end
      if (wr_pllcfg) begin
        pll_mult_r <= reg_wdata[1:0];
      end
    end
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // mode sequencer
  logic load_settle; // start the wait counter
  logic settle_done; // wait counter at zero

  // next mode
  always_comb begin
    state_nxt   = state_r;
    load_settle = 1'b0;
    case (state_r)
      ST_NORMAL: begin
        // stop_select is read only on a standby request
        if (stby_req_r) begin
          state_nxt = stop_sel_r ? ST_STOP : ST_IDLE;
        end else if (halt_req) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!halt_req || release_evt) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_IDLE: begin
        if (release_evt) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_STOP: begin
        // wait always inserted, resonator or external clock
        if (release_evt) begin
          state_nxt = ST_WAIT_OSC;
        end
      end
      ST_WAIT_OSC: begin
        // start-up delay of the oscillator is not counted
        if (os_s2_r) begin
          state_nxt   = ST_SETTLE;
          load_settle = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: begin
        state_nxt = ST_NORMAL;
      end
    endcase
  end

  // mode register; reset leaves stop with no count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wait counter, length from settle select
  sgc_settle_cnt #(
    .CNT_W     (CNT_W),
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_settle (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .load     (load_settle),
    .long_sel (settle_sel_r),
    .done     (settle_done)
  );

  // ==========================================================
  // clock gating
  logic map_osc;
  logic map_pll;
  logic map_sys;
  logic map_per;
  logic map_cpu;
  logic map_wdt;

  // per-mode enable table
  sgc_gate_map u_map (
    .state       (state_r),
    .clk_through (ct_mode_r),
    .fb_dis      (fb_dis_r),
    .osc_en      (map_osc),
    .pll_en      (map_pll),
    .sys_en      (map_sys),
    .per_en      (map_per),
    .cpu_en      (map_cpu),
    .wdt_en      (map_wdt)
  );

  logic osc_en_r;
  logic pll_en_r;
  logic sys_en_r;
  logic per_en_r;
  logic cpu_en_r;
  logic wdt_en_r;
  logic hold_r; // cpu and peripherals held in reset

  // enables registered so outputs are glitch free
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // through mode: clocks run, logic held; pll mode: oscillator only
      osc_en_r <= ~ct_s2_r;
      pll_en_r <= 1'b0;
      sys_en_r <= ct_s2_r;
      per_en_r <= ct_s2_r;
      cpu_en_r <= ct_s2_r;
      wdt_en_r <= ct_s2_r;
      hold_r   <= 1'b1;
    end else begin
      osc_en_r <= map_osc;
      pll_en_r <= map_pll;
      sys_en_r <= map_sys;
      per_en_r <= map_per;
      cpu_en_r <= map_cpu;
      wdt_en_r <= map_wdt;
      hold_r   <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata                 = rdata_r;
  assign osc_en                    = osc_en_r;
  assign pll_en                    = pll_en_r;
  assign sysclk_en                 = sys_en_r;
  assign periph_en                 = per_en_r;
  assign cpu_en                    = cpu_en_r;
  assign wdt_en                    = wdt_en_r;
  assign core_hold                 = hold_r;
  assign pll_mult                  = pll_mult_r;
  assign cpu_div                   = cpu_div_r;
  assign clock_through             = ct_mode_r;
  assign feedback_resistor_disable = fb_dis_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // cycles spent settling, for the length check
  logic [CNT_W-1:0] settle_len_h;
  always_ff @(posedge clock) begin
    if (sys_rst || state_r != ST_SETTLE) begin
      settle_len_h <= '0;
    end else begin
      settle_len_h <= settle_len_h + 1'b1;
    end
  end

  a_idle_entry: assert property (
    state_r == ST_NORMAL && stby_req_r && !stop_sel_r
    |=> state_r == ST_IDLE ##1 !cpu_en && !sysclk_en)
    else $error("idle not entered");

  a_stop_entry: assert property (
    state_r == ST_NORMAL && stby_req_r && stop_sel_r
    |=> state_r == ST_STOP)
    else $error("stop not entered");

  a_select_ignored: assert property (
    state_r == ST_NORMAL && !stby_req_r && !halt_req
    |=> state_r == ST_NORMAL)
    else $error("standby without request");

  a_reset_values: assert property (
    $fell(sys_rst) |-> psmode_rd == 8'h00 && settle_rd == 8'h01)
    else $error("bad register reset value");

  a_bit_write: assert property (
    wr_psmode && reg_bit && reg_wdata[2:0] == 3'h0
    |=> stop_sel_r == $past(reg_wdata[BIT_VAL_POS]))
    else $error("bit write lost");

  a_byte_only: assert property (
    reg_wr && reg_bit && reg_addr == ADR_SETTLE
    |=> $stable(settle_sel_r))
    else $error("bit write hit settle select");

  a_settle_len: assert property (
    state_r == ST_SETTLE && settle_done
    |-> settle_len_h == (settle_sel_r ? CNT_W'(LONG_CYC - 1)
                                      : CNT_W'(SHORT_CYC - 1)))
    else $error("wrong settle length");

  a_osc_wait: assert property (
    state_r == ST_WAIT_OSC && !os_s2_r |=> state_r == ST_WAIT_OSC)
    else $error("counting before oscillation");

  a_stop_gating: assert property (
    state_r == ST_STOP |=> !osc_en && !pll_en && !wdt_en && !cpu_en)
    else $error("clock running in stop");

  a_settle_gating: assert property (
    state_r == ST_SETTLE
    |=> wdt_en && !cpu_en && !sysclk_en && !periph_en)
    else $error("bad gating while settling");

  a_reset_gating: assert property (
    $fell(sys_rst) |-> core_hold && !pll_en &&
                       (cpu_en == ct_mode_r))
    else $error("bad gating in reset");

  a_wake_normal: assert property (
    state_r == ST_IDLE && release_evt
    |=> state_r == ST_NORMAL ##1 cpu_en && !stby_req_r)
    else $error("idle wake failed");

  c_idle: cover property (state_r == ST_IDLE ##1 state_r == ST_NORMAL);
  c_stop: cover property ($fell(state_r == ST_SETTLE));
  c_halt: cover property (state_r == ST_HALT);
  c_bitw: cover property (wr_psmode && reg_bit);

endmodule

//--- verif/sgc_ctrl_test.sv
// testbench: standby sequencing and clock gating of sgc_ctrl
`timescale 1ns/1ps
module sgc_ctrl_test;
  import sgc_pkg::*;
  // ==========================================================
  // design inputs, all given a value at time zero
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       reg_bit = 1'b0;
  logic       halt_req = 1'b0;
  logic       int_req = 1'b0;
  logic       nmi_req = 1'b0;
  logic       osc_stable_pin = 1'b1;
  logic       clock_through_pin = 1'b0;
  // design outputs
  logic [7:0] reg_rdata;
  logic       osc_en, pll_en, sysclk_en, periph_en, cpu_en, wdt_en;
  logic       core_hold, clock_through, feedback_resistor_disable;
  logic [1:0] pll_mult, cpu_div;
  // bench bookkeeping
  logic [7:0] exp_q[$];     // expected read data, oldest first
  logic       rd_d = 1'b0;  // read strobe one cycle late
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         seed = 93;
  int         cnt;
  // enables packed as osc, pll, sys, per, cpu, wdt
  wire  [5:0] en = {osc_en, pll_en, sysclk_en, periph_en, cpu_en, wdt_en};

  // short counts keep the settle waits brief
  sgc_ctrl #(.SHORT_CYC(4), .LONG_CYC(16)) sgc_ctrl_i (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_bit(reg_bit), .reg_rdata(reg_rdata), .halt_req(halt_req),
    .int_req(int_req), .nmi_req(nmi_req),
    .osc_stable_pin(osc_stable_pin),
    .clock_through_pin(clock_through_pin), .osc_en(osc_en),
    .pll_en(pll_en), .sysclk_en(sysclk_en), .periph_en(periph_en),
    .cpu_en(cpu_en), .wdt_en(wdt_en), .core_hold(core_hold),
    .pll_mult(pll_mult), .cpu_div(cpu_div),
    .clock_through(clock_through),
    .feedback_resistor_disable(feedback_resistor_disable));

  // ==========================================================
  // clock: 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end

  // ==========================================================
  // common compare, counts every call
  task automatic check(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // single closing point for normal end and timeouts
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read data stands one cycle after the strobe only
  always @(posedge clock) begin
    rd_d <= reg_rd;
    // take the oldest note whenever read data appears
    if (rd_d && exp_q.size() > 0) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  // ==========================================================
  // register bus tasks: one-cycle strobes, no wait states
  task automatic wr(input logic [7:0] a, d, input logic b = 1'b0);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_bit <= b;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_bit <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask

  // let n edges pass, then sample settled outputs
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one-cycle pulse on a wake source
  task automatic pulse(input logic nmi);
    @(posedge clock);
    if (nmi) nmi_req <= 1'b1;
    else int_req <= 1'b1;
    @(posedge clock);
    nmi_req <= 1'b0;
    int_req <= 1'b0;
  endtask

  // reset for 13 cycles with a given strap, check gating inside
  task automatic rst(input logic ct);
    @(posedge clock);
    sys_rst <= 1'b1;
    clock_through_pin <= ct;
    repeat (12) @(posedge clock);
    #1;
    check("reset_en", {2'b00, en}, {2'b00, ~ct, 1'b0, {4{ct}}});
    check("core_hold", {7'h00, core_hold}, 8'h01);
    @(posedge clock);
    sys_rst <= 1'b0;
  endtask

  // software stop, interrupt wake, timed settle; fb models ext clock
  task automatic stop_run(input logic sel, fb, input int n);
    wr(ADR_PROCCLK, {2'b00, fb, 5'h00});
    wr(ADR_SETTLE, {7'h00, sel});
    wr(ADR_PSMODE, 8'h01);
    osc_stable_pin <= 1'b0;
    wr(ADR_PSCTL, 8'h02);
    idle(3);
    check("stop_en", {2'b00, en}, 8'h00);
    pulse(1'b0);
    // oscillator slow to start: random start-up delay
    idle(3 + ($random(seed) & 7));
    check("wait_en", {2'b00, en}, {2'b00, ~fb, 5'h11});
    @(posedge clock);
    osc_stable_pin <= 1'b1;
    cnt = 0;
    // bounded wait for the cpu clock to return
    while (cpu_en !== 1'b1 && cnt < 200) begin
      idle(1);
      cnt++;
    end
    if (cnt >= 200) begin
      error_cnt++;
      complete_run();
    end
    check("settle_len", 8'(cnt), 8'(n + 4));
    check("norm_en", {2'b00, en}, {2'b00, ~fb, 5'h1F});
    check("fb_dis", 8'(feedback_resistor_disable), 8'(fb));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst(1'b0);
    rd(ADR_PSMODE, 8'h00);
    rd(ADR_SETTLE, 8'h01);
    wr(ADR_PSMODE, 8'h08, 1'b1);
    rd(ADR_PSMODE, 8'h01);
    wr(ADR_SETTLE, 8'h00);
    wr(ADR_SETTLE, 8'h08, 1'b1);
    rd(ADR_SETTLE, 8'h00);
    rd(8'h18 + 8'($random(seed) & 7), 8'h00);
    // stop select alone must not leave normal
    idle(2);
    rd(ADR_STATUS, {2'b10, ST_NORMAL});
    // step off the edge before looking at the enables
    idle(0);
    check("norm_en", {2'b00, en}, 8'h3F);
    // every multiplier code reaches the pll
    for (int i = 0; i < 4; i++) begin
      wr(ADR_PLLCFG, 8'(i));
      wr(ADR_PROCCLK, 8'(i));
      idle(1);
      check("pll_mult", {6'h00, pll_mult}, 8'(i));
      check("cpu_div", {6'h00, cpu_div}, 8'(i));
    end
    // halt stops only the cpu clock; pin driven on the edge
    @(posedge clock);
    halt_req <= 1'b1;
    idle(3);
    check("halt_en", {2'b00, en}, 8'h3D);
    @(posedge clock);
    halt_req <= 1'b0;
    idle(3);
    check("run_en", {2'b00, en}, 8'h3F);
    // idle entry and nmi wake
    wr(ADR_PSMODE, 8'h00);
    // maskable wake disabled: an interrupt must not end idle
    wr(ADR_PSCTL, 8'h12);
    idle(3);
    check("idle_en", {2'b00, en}, 8'h30);
    pulse(1'b0);
    idle(3);
    rd(ADR_STATUS, {2'b10, ST_IDLE});
    pulse(1'b1);
    idle(3);
    check("wake_en", {2'b00, en}, 8'h3F);
    rd(ADR_PSCTL, 8'h10);
    // long and short waits, second on an external clock
    stop_run(1'b1, 1'b0, 16);
    stop_run(1'b0, 1'b1, 4);
    // stop ended by reset: no settle count afterwards
    wr(ADR_PSMODE, 8'h01);
    wr(ADR_PSCTL, 8'h02);
    idle(3);
    rst(1'b1);
    idle(2);
    rd(ADR_STATUS, {2'b11, ST_NORMAL});
    idle(0);
    check("cpu_en", {7'h00, cpu_en}, 8'h01);
    check("through", {7'h00, clock_through}, 8'h01);
    check("core_hold", {7'h00, core_hold}, 8'h00);
    idle(3);
    check("drained", 8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule
